// ---- src/ofsc_pkg.sv ----
// Purpose: shared constants for the overrange flag and serial config link
// Assumes: both ends and the bench use these names
// Notes: register offsets are serial addresses, not bus addresses
package ofsc_pkg;
   // ==========================================================
   // serial register map
   localparam logic [12:0] REG_PORT_CFG = 13'h0000; // bit order, soft reset
   localparam logic [12:0] REG_CHIP_ID = 13'h0001; // identity byte
   localparam logic [12:0] REG_OUT_CLOCK = 13'h0016; // output clock polarity
   localparam logic [12:0] REG_OVR_CTRL = 13'h0111; // overrange_report_control
   localparam int CFG_LSB_HI = 6; // lsb first, upper copy
   localparam int CFG_LSB_LO = 1; // lsb first, lower copy
   localparam int CFG_SRST_HI = 5; // soft reset, upper copy
   localparam int CFG_SRST_LO = 2; // soft reset, lower copy
   localparam logic [7:0] CFG_FIXED = 8'h18; // bits that always read one
   localparam int OCLK_INV_BIT = 7; // output clock inversion
   localparam int OVR_AUTO_BIT = 7; // auto_restart_enable
   localparam int OVR_IND1_BIT = 6; // indicator_select_one
   localparam int OVR_IND2_BIT = 5; // indicator_select_two
   localparam logic [2:0] OVR_RESET = 3'h0; // control bits after reset
   // ==========================================================
   // instruction word layout
   localparam int INSTR_BITS = 16; // instruction length
   localparam int BYTE_BITS = 8; // data unit
   localparam int INSTR_RW_BIT = 15; // one means read
   localparam int INSTR_LEN_HI = 14; // length_sel_high
   localparam int INSTR_LEN_LO = 13; // length_sel_low
   localparam logic [1:0] LEN_STREAM = 2'h3; // streaming length code
   // ==========================================================
   // timing counts in modulator clocks
   localparam int DATA_LATENCY = 7; // conversion to output
   localparam int OVR_PERSIST = 16; // cycles before auto reset
   localparam int AUTO_RST_CYCLES = 4; // length of the modulator reset
   localparam int SYNC_STAGES = 3; // pin synchroniser depth
   // ==========================================================
   // host bus map, byte addresses
   localparam logic [3:0] HOST_CTRL = 4'h0; // rw, length, address, order
   localparam logic [3:0] HOST_WDATA = 4'h4; // bytes to send
   localparam logic [3:0] HOST_STATUS = 4'h8; // busy
   localparam logic [3:0] HOST_RDATA = 4'hC; // bytes received
   localparam int CTRL_LSB_BIT = 16; // host bit order
endpackage

// ---- src/ofsc_if.sv ----
// Purpose: three-wire serial link between host and device
// Assumes: an idle data line floats high by pull-up
// Notes: the line level is resolved here from both enables
`timescale 1ns/1ps
`default_nettype none
interface ofsc_if;
   // ==========================================================
   // link wires
   logic sclk; // serial clock from host
   logic chip_select_low; // frame gate, active low
   logic host_sdio_o; // host data out
   logic host_sdio_oe; // host drives line
   logic dev_sdio_o; // device data out
   logic dev_sdio_oe; // device drives line
   logic sdio; // resolved line level
   // pull-up when nobody drives
   assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
   modport dev (input sclk, input chip_select_low, input sdio, output dev_sdio_o, output dev_sdio_oe);
   modport host (output sclk, output chip_select_low, output host_sdio_o, output host_sdio_oe, input sdio);
endinterface
`default_nettype wire

// ---- src/ofsc_device.sv ----
// Purpose: converter control side: overrange flag, output timing, serial port
// Assumes: modulator status inputs come from logic on CLOCK_I
// Notes: link pins are sampled by CLOCK_I through three flip-flops
`timescale 1ns/1ps
`default_nettype none
module ofsc_device #(
   parameter int SAMPLE_W = 4, // output sample width
   parameter logic [7:0] CHIP_ID = 8'h5A // arbitrary identity value
) (
   input wire logic CLOCK_I, // modulator clock
   input wire logic RST_N_I, // synchronous reset, active low
   input wire logic [SAMPLE_W-1:0] SAMPLE_I, // conversion result each clock
   input wire logic OVERRANGE_I, // modulator overranged
   input wire logic LOOP_SAT_I, // loop filter saturated
   input wire logic MEM_ACCESS_I, // internal memory transfer busy
   ofsc_if.dev SPI, // serial link
   output logic [SAMPLE_W-1:0] DATA_O, // output sample
   output logic DCO_O, // data_output_clock
   output logic OVR_FLAG_O, // overrange flag
   output logic MOD_RESET_O, // modulator reset
   output logic [1:0] STRAP_O // multiplier_strap_bit1, multiplier_strap_bit0
);
   typedef enum logic [1:0] {SP_IDLE = 2'b00, SP_INSTR = 2'b01, SP_DATA = 2'b10, SP_DONE = 2'b11} ofsc_sp_t;
   // ==========================================================
   // control registers
   logic lsb_first; // serial bit order
   logic dco_inv; // output clock inversion
   logic [2:0] ovr_ctrl; // auto, ind1, ind2
   logic strap_taken; // straps captured once
   // ==========================================================
   // pin synchroniser: sclk, select, data
   logic [2:0] sync1, sync2, sync3, filt, filt_prev;
   always_ff @(posedge CLOCK_I) begin
      sync1 <= {SPI.sclk, SPI.chip_select_low, SPI.sdio};
      sync2 <= sync1;
      sync3 <= sync2;
   end
   // a change counts once the later stages agree
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_filt
         logic f; // filtered level of this pin, one driver per bit
         always_ff @(posedge CLOCK_I) begin
            if (!RST_N_I) begin
               f <= 1'b1;
            end else if (sync2[gi] == sync3[gi]) begin
               f <= sync3[gi];
            end
         end
         assign filt[gi] = f;
      end
   endgenerate
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         filt_prev <= 3'h7;
      end else begin
         filt_prev <= filt;
      end
   end
   logic sel, sck_rise, sck_fall, sdi;
   assign sel = !filt[1];
   assign sck_rise = filt[2] & !filt_prev[2];
   assign sck_fall = !filt[2] & filt_prev[2];
   assign sdi = filt[0];
   // ==========================================================
   // strap capture after reset release
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         strap_taken <= 1'b0;
         STRAP_O <= 2'h0;
      end else if (!strap_taken && filt_prev == filt && filt == sync3) begin
         // wait until the filter holds real pin levels, not its reset value
         strap_taken <= 1'b1;
         STRAP_O <= {filt[0], filt[2]};
      end
   end
   // ==========================================================
   // register read decode
   function automatic logic [7:0] reg_read(input logic [12:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ofsc_pkg::REG_PORT_CFG: begin
            v = ofsc_pkg::CFG_FIXED;
            v[ofsc_pkg::CFG_LSB_HI] = lsb_first;
            v[ofsc_pkg::CFG_LSB_LO] = lsb_first;
         end
         ofsc_pkg::REG_CHIP_ID: v = CHIP_ID;
         ofsc_pkg::REG_OUT_CLOCK: v[ofsc_pkg::OCLK_INV_BIT] = dco_inv;
         ofsc_pkg::REG_OVR_CTRL: v[ofsc_pkg::OVR_AUTO_BIT -: 3] = ovr_ctrl;
         default: v = 8'h00;
      endcase
      return v;
   endfunction
   // ==========================================================
   // serial frame engine
   ofsc_sp_t state;
   logic [15:0] instr_sr; // instruction shifter
   logic [3:0] bit_cnt; // bits within instruction or byte
   logic [7:0] rx_byte, out_byte;
   logic [12:0] addr; // current register address
   logic rd, stream;
   logic [1:0] left; // bytes still to come after this one
   logic [15:0] next_instr;
   logic [7:0] next_byte;
   logic wr_en; // byte write strobe
   assign next_instr = lsb_first ? {sdi, instr_sr[15:1]} : {instr_sr[14:0], sdi};
   assign next_byte = lsb_first ? {sdi, rx_byte[7:1]} : {rx_byte[6:0], sdi};
   assign wr_en = sel && sck_rise && state == SP_DATA && !rd && bit_cnt == 4'(ofsc_pkg::BYTE_BITS - 1);
   // next address follows bit order direction
   logic [12:0] next_addr;
   assign next_addr = lsb_first ? addr + 13'h0001 : addr - 13'h0001;
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         state <= SP_IDLE;
         bit_cnt <= 4'h0;
         instr_sr <= 16'h0000;
         rx_byte <= 8'h00;
         out_byte <= 8'h00;
         addr <= 13'h0000;
         rd <= 1'b0;
         stream <= 1'b0;
         left <= 2'h0;
      end else if (!sel) begin
         // pause only at a byte boundary with bytes owed
         if (!(state == SP_DATA && bit_cnt == 4'h0 && !stream && left != 2'h0 && filt_prev[2:1] == 2'h0)) begin
            if (state != SP_DATA || bit_cnt != 4'h0 || stream || left == 2'h0) begin
               state <= SP_IDLE;
            end
         end
         bit_cnt <= (state == SP_DATA && bit_cnt == 4'h0) ? bit_cnt : 4'h0;
      end else if (sck_rise) begin
         case (state)
            SP_IDLE: begin
               instr_sr <= next_instr;
               bit_cnt <= 4'h1;
               state <= SP_INSTR;
            end
            SP_INSTR: begin
               instr_sr <= next_instr;
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'(ofsc_pkg::INSTR_BITS - 1)) begin
                  rd <= next_instr[ofsc_pkg::INSTR_RW_BIT];
                  left <= next_instr[ofsc_pkg::INSTR_LEN_HI:ofsc_pkg::INSTR_LEN_LO];
                  stream <= next_instr[ofsc_pkg::INSTR_LEN_HI:ofsc_pkg::INSTR_LEN_LO] == ofsc_pkg::LEN_STREAM;
                  addr <= next_instr[12:0];
                  out_byte <= reg_read(next_instr[12:0]);
                  bit_cnt <= 4'h0;
                  state <= SP_DATA;
               end
            end
            SP_DATA: begin
               rx_byte <= next_byte;
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'(ofsc_pkg::BYTE_BITS - 1)) begin
                  bit_cnt <= 4'h0;
                  addr <= next_addr;
                  out_byte <= reg_read(next_addr);
                  if (stream) begin
                     state <= SP_DATA;
                  end else if (left == 2'h0) begin
                     state <= SP_DONE;
                  end else begin
                     left <= left - 2'h1;
                  end
               end
            end
            default: state <= SP_DONE; // extra clocks ignored until deselect
         endcase
      end
   end
   // ==========================================================
   // data line turnaround, driven on falling sclk
   logic sdo, sdo_oe;
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
      end else if (!sel) begin
         sdo_oe <= 1'b0;
      end else if (sck_fall && state == SP_DATA && rd) begin
         sdo_oe <= 1'b1;
         sdo <= lsb_first ? out_byte[bit_cnt[2:0]] : out_byte[3'(7 - bit_cnt[2:0])];
      end
   end
   assign SPI.dev_sdio_o = sdo;
   assign SPI.dev_sdio_oe = sdo_oe;
   // ==========================================================
   // register writes, soft reset restores dco_inv and ovr_ctrl defaults
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         lsb_first <= 1'b0;
         dco_inv <= 1'b0;
         ovr_ctrl <= ofsc_pkg::OVR_RESET;
      end else if (wr_en) begin
         case (addr)
            ofsc_pkg::REG_PORT_CFG: begin
               lsb_first <= next_byte[ofsc_pkg::CFG_LSB_HI] | next_byte[ofsc_pkg::CFG_LSB_LO];
               if (next_byte[ofsc_pkg::CFG_SRST_HI] | next_byte[ofsc_pkg::CFG_SRST_LO]) begin
                  dco_inv <= 1'b0;
                  ovr_ctrl <= ofsc_pkg::OVR_RESET;
               end
            end
            ofsc_pkg::REG_OUT_CLOCK: dco_inv <= next_byte[ofsc_pkg::OCLK_INV_BIT];
            ofsc_pkg::REG_OVR_CTRL: ovr_ctrl <= next_byte[ofsc_pkg::OVR_AUTO_BIT -: 3];
            default: lsb_first <= lsb_first; // other addresses are read only
         endcase
      end
   end
   // ==========================================================
   // auto reset: persistence count and reset pulse
   logic [4:0] persist; // consecutive overrange cycles
   logic [2:0] rst_cnt; // remaining reset cycles
   logic in_reset;
   assign in_reset = rst_cnt != 3'h0;
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         persist <= 5'h00;
         rst_cnt <= 3'h0;
         MOD_RESET_O <= 1'b0;
      end else begin
         MOD_RESET_O <= in_reset;
         if (in_reset) begin
            rst_cnt <= rst_cnt - 3'h1;
            persist <= 5'h00;
         end else if (ovr_ctrl[2] && (LOOP_SAT_I || persist == 5'(ofsc_pkg::OVR_PERSIST - 1) && OVERRANGE_I)) begin
            rst_cnt <= 3'(ofsc_pkg::AUTO_RST_CYCLES);
            persist <= 5'h00;
         end else if (OVERRANGE_I) begin
            persist <= persist + 5'h01;
         end else begin
            persist <= 5'h00;
         end
      end
   end
   // ==========================================================
   // output data pipeline and data_output_clock
   logic [SAMPLE_W-1:0] pipe [ofsc_pkg::DATA_LATENCY-1];
   logic phase; // output sample phase
   always_ff @(posedge CLOCK_I) begin
      pipe[0] <= SAMPLE_I;
      for (int i = 1; i < ofsc_pkg::DATA_LATENCY - 1; i++) begin
         pipe[i] <= pipe[i-1];
      end
   end
   // flag value per reporting mode
   logic flag_val;
   always_comb begin
      case (ovr_ctrl[1:0])
         2'h3: flag_val = !(MEM_ACCESS_I || (ovr_ctrl[2] && in_reset));
         default: flag_val = OVERRANGE_I || (ovr_ctrl[2] && in_reset);
      endcase
   end
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         phase <= 1'b0;
         DCO_O <= 1'b0;
         DATA_O <= '0;
         OVR_FLAG_O <= 1'b0;
      end else begin
         phase <= !phase;
         DCO_O <= phase ^ dco_inv;
         if (!phase) begin
            DATA_O <= pipe[ofsc_pkg::DATA_LATENCY-2];
            OVR_FLAG_O <= flag_val;
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/ofsc_host.sv ----
// Purpose: host controller for the three-wire configuration link
// Assumes: software drives Avalon-MM with waitrequest
// Notes: sclk is divided from CLOCK_I; read data sampled at end of high phase
`timescale 1ns/1ps
`default_nettype none
module ofsc_host #(
   parameter int SCLK_HALF = 8 // clocks per sclk half period
) (
   input wire logic CLOCK_I, // system clock
   input wire logic RST_N_I, // synchronous reset, active low
   input wire logic [3:0] AVS_ADDRESS_I, // byte address
   input wire logic AVS_READ_I, // read request
   input wire logic AVS_WRITE_I, // write request
   input wire logic [31:0] AVS_WRITEDATA_I, // write data
   output logic [31:0] AVS_READDATA_O, // read data
   output logic AVS_WAITREQUEST_O, // stall
   ofsc_if.host SPI // serial link
);
   typedef enum logic [2:0] {H_IDLE = 3'b000, H_SETUP = 3'b001, H_LOW = 3'b010, H_HIGH = 3'b011,
      H_HOLD = 3'b100} ofsc_h_t;
   // ==========================================================
   // bus slave, one wait cycle per access
   logic [16:0] ctrl; // order, rw, length, address
   logic [31:0] wdata, rdata;
   logic busy, start;
   assign start = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == ofsc_pkg::HOST_CTRL && !busy;
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O <= 32'h00000000;
         ctrl <= 17'h00000;
         wdata <= 32'h00000000;
      end else begin
         AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
         if (AVS_READ_I && AVS_WAITREQUEST_O) begin
            case (AVS_ADDRESS_I)
               ofsc_pkg::HOST_CTRL: AVS_READDATA_O <= {15'h0000, ctrl};
               ofsc_pkg::HOST_WDATA: AVS_READDATA_O <= wdata;
               ofsc_pkg::HOST_STATUS: AVS_READDATA_O <= {31'h00000000, busy};
               ofsc_pkg::HOST_RDATA: AVS_READDATA_O <= rdata;
               default: AVS_READDATA_O <= 32'h00000000; // unmapped reads zero
            endcase
         end
         if (start) begin
            ctrl <= AVS_WRITEDATA_I[16:0];
         end
         if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == ofsc_pkg::HOST_WDATA) begin
            wdata <= AVS_WRITEDATA_I;
         end
      end
   end
   // ==========================================================
   // read data synchroniser
   logic s1, s2, s3, sdi;
   always_ff @(posedge CLOCK_I) begin
      s1 <= SPI.sdio;
      s2 <= s1;
      s3 <= s2;
   end
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         sdi <= 1'b1;
      end else if (s2 == s3) begin
         sdi <= s3;
      end
   end
   // ==========================================================
   // frame engine
   ofsc_h_t state;
   logic [7:0] div;
   logic [5:0] bit_idx, bit_total;
   logic [47:0] tx;
   logic lsb, rd;
   logic sclk, csl, sdo, sdo_oe;
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         state <= H_IDLE;
         div <= 8'h00;
         bit_idx <= 6'h00;
         bit_total <= 6'h00;
         tx <= 48'h000000000000;
         lsb <= 1'b0;
         rd <= 1'b0;
         busy <= 1'b0;
         rdata <= 32'h00000000;
         sclk <= 1'b0;
         csl <= 1'b1;
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         div <= div + 8'h01;
         case (state)
            H_IDLE: begin
               if (start) begin
                  busy <= 1'b1;
                  lsb <= AVS_WRITEDATA_I[ofsc_pkg::CTRL_LSB_BIT];
                  rd <= AVS_WRITEDATA_I[ofsc_pkg::INSTR_RW_BIT];
                  bit_total <= 6'(ofsc_pkg::INSTR_BITS) + 6'(ofsc_pkg::BYTE_BITS) * (6'h1 +
                     6'(AVS_WRITEDATA_I[ofsc_pkg::INSTR_LEN_HI:ofsc_pkg::INSTR_LEN_LO]));
                  tx <= AVS_WRITEDATA_I[ofsc_pkg::CTRL_LSB_BIT] ? {wdata, AVS_WRITEDATA_I[15:0]} :
                     {AVS_WRITEDATA_I[15:0], wdata[7:0], wdata[15:8], wdata[23:16], wdata[31:24]};
                  rdata <= 32'h00000000;
                  csl <= 1'b0;
                  div <= 8'h00;
                  state <= H_SETUP;
               end
            end
            H_SETUP: begin
               if (div == 8'(SCLK_HALF - 1)) begin
                  div <= 8'h00;
                  bit_idx <= 6'h00;
                  state <= H_LOW;
               end
            end
            H_LOW: begin
               if (div == 8'h00) begin
                  sdo <= lsb ? tx[0] : tx[47];
                  sdo_oe <= !(rd && bit_idx >= 6'(ofsc_pkg::INSTR_BITS));
               end
               if (div == 8'(SCLK_HALF - 1)) begin
                  div <= 8'h00;
                  sclk <= 1'b1;
                  state <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (div == 8'(SCLK_HALF - 1)) begin
                  div <= 8'h00;
                  sclk <= 1'b0;
                  tx <= lsb ? {1'b0, tx[47:1]} : {tx[46:0], 1'b0};
                  if (rd && bit_idx >= 6'(ofsc_pkg::INSTR_BITS)) begin
                     rdata <= lsb ? {sdi, rdata[31:1]} : {rdata[30:0], sdi};
                  end
                  bit_idx <= bit_idx + 6'h01;
                  state <= (bit_idx == bit_total - 6'h01) ? H_HOLD : H_LOW;
               end
            end
            H_HOLD: begin
               sdo_oe <= 1'b0;
               if (div == 8'(SCLK_HALF - 1)) begin
                  csl <= 1'b1;
                  busy <= 1'b0;
                  state <= H_IDLE;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end
   assign SPI.sclk = sclk;
   assign SPI.chip_select_low = csl;
   assign SPI.host_sdio_o = sdo;
   assign SPI.host_sdio_oe = sdo_oe;
endmodule
`default_nettype wire

// ---- sim/ofsc_sva.sv ----
// Purpose: wire checks between host and device ends
// Assumes: one clock, synchronous active low reset
// Notes: sees the link signals only
`timescale 1ns/1ps
`default_nettype none
module ofsc_sva (
   input wire logic CLOCK_I, // system clock
   input wire logic RST_N_I, // reset, active low
   input wire logic sclk, // serial clock
   input wire logic chip_select_low, // frame gate
   input wire logic host_sdio_oe, // host drives line
   input wire logic dev_sdio_oe // device drives line
);
   // ==========================================================
   // link properties
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   a_no_contention: assert property (!(dev_sdio_oe && host_sdio_oe))
      else $error("both ends drive the data line");
   a_dev_released: assert property (chip_select_low [*6] |-> !dev_sdio_oe)
      else $error("device drives while deselected");
   a_host_quiet: assert property (chip_select_low && $past(chip_select_low) |-> !host_sdio_oe)
      else $error("host drives outside a frame");
   a_sclk_still: assert property (chip_select_low && $past(chip_select_low) |-> !sclk)
      else $error("serial clock moves outside a frame");
   a_sclk_in_frame: assert property ($rose(sclk) |-> !chip_select_low)
      else $error("serial clock rise while deselected");
   a_oe_in_frame: assert property ($rose(dev_sdio_oe) |-> !chip_select_low)
      else $error("device turns line while deselected");
   a_turn_low_phase: assert property ($rose(dev_sdio_oe) |-> !sclk && !host_sdio_oe)
      else $error("turnaround outside low phase");
   a_oe_holds: assert property (dev_sdio_oe && !chip_select_low |=> dev_sdio_oe)
      else $error("device drops line inside a read");
   a_frame_setup: assert property ($fell(chip_select_low) |-> !sclk [*8])
      else $error("first clock too soon after select");
   // main scenarios reached
   c_frame: cover property ($fell(chip_select_low));
   c_read: cover property ($rose(dev_sdio_oe));
   c_bit: cover property ($rose(sclk));
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: drives both link ends from the host bus
// Assumes: 50 MHz clock, bus stalls by waitrequest
// Notes: reset length and port config expectations come from package constants, the rest are literals
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ==========================================================
   // clock, reset and pins
   localparam logic [7:0] ID = 8'h3C; // arbitrary identity value
   logic clock = 1'b0; // 20 ns period
   logic rst_n = 1'b0; // held low at start
   logic [3:0] addr = 4'h0; // bus address
   logic rd = 1'b0; // bus read
   logic wr = 1'b0; // bus write
   logic [31:0] wdata = 32'h0; // bus write data
   logic [31:0] rdata; // bus read data
   logic waitreq; // bus stall
   logic ovr = 1'b0; // overrange input
   logic sat = 1'b0; // saturation input
   logic mem = 1'b0; // memory access input
   logic flag; // overrange flag
   logic mod_rst; // modulator reset
   logic [1:0] strap; // strap capture
   logic [3:0] smp = 4'h0; // conversion sample
   logic [3:0] dout; // output sample
   logic dco; // output clock
   logic [31:0] q; // last bus answer
   int errors = 0; // mismatches
   int n_compared = 0; // comparisons
   int rst_len = 0; // modulator reset cycles
   always #10 clock = ~clock;
   // count reset cycles where settled
   always @(negedge clock) if (mod_rst === 1'b1) rst_len++;
   ofsc_if ofsc_if_inst ();
   ofsc_host ofsc_host_inst (.CLOCK_I(clock), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
      .SPI(ofsc_if_inst.host));
   ofsc_device #(.CHIP_ID(ID)) ofsc_device_inst (.CLOCK_I(clock), .RST_N_I(rst_n), .SAMPLE_I(smp),
      .OVERRANGE_I(ovr), .LOOP_SAT_I(sat), .MEM_ACCESS_I(mem), .SPI(ofsc_if_inst.dev), .DATA_O(dout),
      .DCO_O(dco), .OVR_FLAG_O(flag), .MOD_RESET_O(mod_rst), .STRAP_O(strap));
   ofsc_sva ofsc_sva_inst (.CLOCK_I(clock), .RST_N_I(rst_n), .sclk(ofsc_if_inst.sclk),
      .chip_select_low(ofsc_if_inst.chip_select_low), .host_sdio_oe(ofsc_if_inst.host_sdio_oe),
      .dev_sdio_oe(ofsc_if_inst.dev_sdio_oe));
   // ==========================================================
   // tasks
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one bus cycle, held until waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clock);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clock);
         i++;
      end while (waitreq !== 1'b0 && i < 100);
      if (i >= 100) begin
         errors++;
         final_report();
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   // one serial frame, then fetch received bytes
   task automatic spi(input logic [31:0] ctrl, input logic [31:0] d);
      int i;
      i = 0;
      bus(1'b1, ofsc_pkg::HOST_WDATA, d);
      bus(1'b1, ofsc_pkg::HOST_CTRL, ctrl);
      do begin
         bus(1'b0, ofsc_pkg::HOST_STATUS, 32'h0);
         i++;
      end while (q[0] !== 1'b0 && i < 500);
      if (i >= 500) begin
         errors++;
         final_report();
      end
      bus(1'b0, ofsc_pkg::HOST_RDATA, 32'h0);
   endtask
   function automatic logic [31:0] cmd(input logic lsb, input logic r, input logic [12:0] a);
      return {15'h0, lsb, r, 2'h0, a};
   endfunction
   // sample the flag while the output clock is high, after its rise
   task automatic flag_is(input logic v);
      int i;
      i = 0;
      repeat (4) @(posedge clock);
      do begin
         @(negedge clock);
         i++;
      end while (dco !== 1'b1 && i < 8);
      if (i >= 8) begin
         errors++;
         final_report();
      end
      check(32'(flag), 32'(v));
      @(posedge clock);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      repeat (10) @(posedge clock);
      check(32'(strap), 32'h2);
      spi(cmd(1'b0, 1'b1, ofsc_pkg::REG_CHIP_ID), 32'h0);
      check(32'(q[7:0]), 32'(ID));
      spi(cmd(1'b0, 1'b1, ofsc_pkg::REG_OVR_CTRL), 32'h0);
      check(32'(q[7:0]), 32'h0);
      spi(cmd(1'b0, 1'b0, ofsc_pkg::REG_OVR_CTRL), 32'hE0);
      spi(cmd(1'b0, 1'b1, ofsc_pkg::REG_OVR_CTRL), 32'h0);
      check(32'(q[7:0]), 32'hE0);
      $display("registers done");
      spi(cmd(1'b0, 1'b0, ofsc_pkg::REG_OVR_CTRL), 32'h00);
      ovr <= 1'b1;
      flag_is(1'b1);
      ovr <= 1'b0;
      flag_is(1'b0);
      spi(cmd(1'b0, 1'b0, ofsc_pkg::REG_OVR_CTRL), 32'h60);
      flag_is(1'b1);
      mem <= 1'b1;
      flag_is(1'b0);
      mem <= 1'b0;
      $display("flag modes done");
      spi(cmd(1'b0, 1'b0, ofsc_pkg::REG_OVR_CTRL), 32'h80);
      rst_len = 0;
      ovr <= 1'b1;
      repeat (15) @(posedge clock);
      ovr <= 1'b0;
      repeat (12) @(posedge clock);
      check(32'(rst_len), 32'h0);
      ovr <= 1'b1;
      repeat (16) @(posedge clock);
      ovr <= 1'b0;
      repeat (12) @(posedge clock);
      check(32'(rst_len), 32'(ofsc_pkg::AUTO_RST_CYCLES));
      rst_len = 0;
      sat <= 1'b1;
      @(posedge clock);
      sat <= 1'b0;
      repeat (12) @(posedge clock);
      check(32'(rst_len), 32'(ofsc_pkg::AUTO_RST_CYCLES));
      $display("auto reset done");
      spi(cmd(1'b0, 1'b0, ofsc_pkg::REG_PORT_CFG), 32'h42);
      spi(cmd(1'b1, 1'b1, ofsc_pkg::REG_PORT_CFG), 32'h0);
      check(32'(q[31:24]), 32'(ofsc_pkg::CFG_FIXED | 8'h42));
      spi(cmd(1'b1, 1'b0, ofsc_pkg::REG_PORT_CFG), 32'h0);
      spi(cmd(1'b0, 1'b1, ofsc_pkg::REG_CHIP_ID), 32'h0);
      check(32'(q[7:0]), 32'(ID));
      $display("bit order done");
      smp <= 4'h9;
      repeat (ofsc_pkg::DATA_LATENCY + 2) @(posedge clock);
      check(32'(dout), 32'h9);
      $display("output data done");
      final_report();
   end
endmodule
`default_nettype wire
